// ---- hw/wqg_group_table.v ----
// Work queue group configuration table: storage, lock, and dispatch permission.
// Assumes the table offset, device state and capability bits come from neighbouring registers.
`timescale 1ns/1ps
`default_nettype none
`include "wqg_map.vh"

module wqg_group_table #(
   parameter NUM_GROUPS = 4,
   parameter NUM_WQ = 8,
   parameter NUM_ENG = 4,
   parameter QIDX_W = 3,
   parameter SIZE_W = 16,
   parameter ADDR_W = 32
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire reset_in,
   // Register port
   input wire reg_wr_en_in,
   input wire reg_rd_en_in,
   input wire [ADDR_W-1:0] reg_addr_in,
   input wire [63:0] reg_wdata_in,
   output reg [63:0] reg_rdata_out,
   output reg reg_rvalid_out,
   // Neighbouring configuration
   input wire [ADDR_W-1:0] table_offset_in,
   input wire device_disabled_in,
   input wire config_support_in,
   input wire [NUM_WQ*SIZE_W-1:0] queue_size_in,
   // Status and dispatch
   output reg [7:0] group_count_out,
   output reg [NUM_WQ-1:0] queue_active_out,
   output reg [NUM_ENG-1:0] engine_active_out,
   input wire [QIDX_W-1:0] dispatch_queue_in,
   output reg [NUM_ENG-1:0] dispatch_engines_out
);

   localparam [ADDR_W-1:0] TABLE_BYTES = NUM_GROUPS << `WQG_STRIDE_SHIFT;
   localparam QPAD = `WQG_QUEUE_MASK_W - NUM_WQ;
   localparam EPAD = `WQG_ENGINE_MASK_W - NUM_ENG;
   localparam FPAD = `WQG_FLAGS_W - `WQG_FLAGS_IMPL_W;
   localparam LPAD = `WQG_LANE_W - `WQG_FLAGS_W;

   // Address decode
   wire [ADDR_W-1:0] rel_addr;
   wire above_base;
   wire below_end;
   wire in_table;
   wire aligned;
   wire [ADDR_W-`WQG_STRIDE_SHIFT-1:0] grp_sel;
   wire [2:0] word_sel;
   wire sel_queue;
   wire sel_engine;
   wire sel_flags;
   wire unlocked;
   wire wr_ok;

   assign rel_addr = reg_addr_in - table_offset_in; // RQ2
   // Subtraction wraps below the base, so the lower bound is checked apart
   assign above_base = (reg_addr_in >= table_offset_in); // RQ2
   assign below_end = (rel_addr < TABLE_BYTES); // RQ4
   assign in_table = above_base && below_end; // RQ4
   assign aligned = (rel_addr[`WQG_WORD_SHIFT-1:0] == {`WQG_WORD_SHIFT{1'b0}});
   assign grp_sel = rel_addr[ADDR_W-1:`WQG_STRIDE_SHIFT]; // RQ16
   assign word_sel = rel_addr[`WQG_STRIDE_SHIFT-1:`WQG_WORD_SHIFT]; // RQ16
   assign sel_queue = (word_sel <= `WQG_WORD_QUEUE_LAST); // RQ16
   assign sel_engine = (word_sel == `WQG_WORD_ENGINE); // RQ16
   assign sel_flags = (word_sel == `WQG_WORD_FLAGS); // RQ16
   // Both lock conditions gate the one write strobe, so a locked write never lands
   assign unlocked = device_disabled_in && config_support_in; // RQ11 RQ12
   assign wr_ok = reg_wr_en_in && in_table && aligned && unlocked; // RQ17

   // Per-group results fold into these chains, one group at a time
   wire [`WQG_LANE_W*(NUM_GROUPS+1)-1:0] rd_chain;
   wire [NUM_ENG*(NUM_GROUPS+1)-1:0] eng_chain;
   wire [NUM_ENG*(NUM_GROUPS+1)-1:0] disp_chain;

   assign rd_chain[`WQG_LANE_W-1:0] = {`WQG_LANE_W{1'b0}};
   assign eng_chain[NUM_ENG-1:0] = {NUM_ENG{1'b0}};
   assign disp_chain[NUM_ENG-1:0] = {NUM_ENG{1'b0}};

   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g = g + 1) begin : grp
         reg [NUM_WQ-1:0] q_reg;
         reg [NUM_ENG-1:0] e_reg;
         reg [`WQG_FLAGS_IMPL_W-1:0] f_reg;
         reg [`WQG_QUEUE_MASK_W-1:0] q_wide;
         reg [`WQG_LANE_W-1:0] rd_word;
         wire [`WQG_QUEUE_MASK_W-1:0] q_full;
         wire [`WQG_ENGINE_MASK_W-1:0] e_full;
         wire [`WQG_FLAGS_W-1:0] f_full;
         wire hit;
         wire hit_q;
         wire hit_e;
         wire hit_f;
         wire rd_hit;
         wire holds_queue;

         assign q_full = {{QPAD{1'b0}}, q_reg}; // RQ13 RQ14 RQ18
         assign e_full = {{EPAD{1'b0}}, e_reg}; // RQ15 RQ18
         assign f_full = {{FPAD{1'b0}}, f_reg}; // RQ18
         // One write strobe per sub-register
         assign hit = wr_ok && (grp_sel == g);
         assign hit_q = hit && sel_queue;
         assign hit_e = hit && sel_engine;
         assign hit_f = hit && sel_flags;
         // Reserved group slots and unaligned reads match no entry
         assign rd_hit = in_table && aligned && (grp_sel == g); // RQ4 RQ18
         assign holds_queue = q_full[dispatch_queue_in]; // RQ6

         // Splice the written lane into the stored mask
         always @* begin
            q_wide = q_full;
            q_wide[word_sel[1:0]*`WQG_LANE_W +: `WQG_LANE_W] = reg_wdata_in;
         end

         // Bits above the implemented queues are dropped here
         always @(posedge clk_sys_in) begin
            if (reset_in) begin
               q_reg <= {NUM_WQ{1'b0}};
            end else if (hit_q) begin
               q_reg <= q_wide[NUM_WQ-1:0]; // RQ13 RQ14 RQ18
            end
         end

         // Engine mask
         always @(posedge clk_sys_in) begin
            if (reset_in) begin
               e_reg <= {NUM_ENG{1'b0}};
            end else if (hit_e) begin
               e_reg <= reg_wdata_in[NUM_ENG-1:0]; // RQ15 RQ18
            end
         end

         // Flags keep only the implemented low bits
         always @(posedge clk_sys_in) begin
            if (reset_in) begin
               f_reg <= {`WQG_FLAGS_IMPL_W{1'b0}};
            end else if (hit_f) begin
               f_reg <= reg_wdata_in[`WQG_FLAGS_IMPL_W-1:0]; // RQ18
            end
         end

         // Read word of this entry; holes in the entry read as zero
         always @* begin
            rd_word = {`WQG_LANE_W{1'b0}};
            if (sel_queue) begin
               rd_word = q_full[word_sel[1:0]*`WQG_LANE_W +: `WQG_LANE_W]; // RQ13
            end else if (sel_engine) begin
               rd_word = e_full; // RQ15
            end else if (sel_flags) begin
               rd_word = {{LPAD{1'b0}}, f_full}; // RQ18
            end
         end

         assign rd_chain[(g+1)*`WQG_LANE_W +: `WQG_LANE_W] =
            rd_chain[g*`WQG_LANE_W +: `WQG_LANE_W] | (rd_hit ? rd_word : {`WQG_LANE_W{1'b0}}); // RQ4
         assign eng_chain[(g+1)*NUM_ENG +: NUM_ENG] = eng_chain[g*NUM_ENG +: NUM_ENG] | e_reg; // RQ10
         assign disp_chain[(g+1)*NUM_ENG +: NUM_ENG] =
            disp_chain[g*NUM_ENG +: NUM_ENG] | (holds_queue ? e_reg : {NUM_ENG{1'b0}}); // RQ1 RQ6
      end
   endgenerate

   // Queue activity follows the size fields
   wire [NUM_WQ-1:0] queue_active_next;
   genvar w;
   generate
      for (w = 0; w < NUM_WQ; w = w + 1) begin : wq
         assign queue_active_next[w] = |queue_size_in[w*SIZE_W +: SIZE_W]; // RQ8
      end
   endgenerate

   // Read data and dispatch permission
   wire [`WQG_LANE_W-1:0] rdata_next;
   wire [NUM_ENG-1:0] engine_active_next;
   wire [NUM_ENG-1:0] eng_allowed;
   wire [NUM_ENG-1:0] dispatch_next;
   wire queue_idle;

   assign rdata_next = rd_chain[NUM_GROUPS*`WQG_LANE_W +: `WQG_LANE_W]; // RQ4 RQ18
   assign engine_active_next = eng_chain[NUM_GROUPS*NUM_ENG +: NUM_ENG]; // RQ10
   assign eng_allowed = disp_chain[NUM_GROUPS*NUM_ENG +: NUM_ENG] & engine_active_next; // RQ6 RQ10
   // An idle queue has nowhere to send work
   assign queue_idle = !queue_active_next[dispatch_queue_in]; // RQ8
   assign dispatch_next = queue_idle ? {NUM_ENG{1'b0}} : eng_allowed; // RQ8

   // A read in the same cycle as a write sees the old value
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         reg_rdata_out <= {`WQG_LANE_W{1'b0}};
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rdata_out <= reg_rd_en_in ? rdata_next : {`WQG_LANE_W{1'b0}};
         reg_rvalid_out <= reg_rd_en_in;
      end
   end

   // Group count is fixed, but still leaves through a flip-flop
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         group_count_out <= 8'h0;
      end else begin
         group_count_out <= NUM_GROUPS[7:0]; // RQ3
      end
   end

   // Status outputs lag their inputs by one cycle
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         queue_active_out <= {NUM_WQ{1'b0}};
         engine_active_out <= {NUM_ENG{1'b0}};
         dispatch_engines_out <= {NUM_ENG{1'b0}};
      end else begin
         queue_active_out <= queue_active_next; // RQ8
         engine_active_out <= engine_active_next; // RQ10
         dispatch_engines_out <= dispatch_next; // RQ6
      end
   end

endmodule
`default_nettype wire

// ---- include/wqg_map.vh ----
// Constants for the work queue group configuration table.
// Assumes byte addresses inside the memory-mapped base region, 64-bit accesses.
// Functional notes
// RQ1 - Group register array maps work queues to engines; base comes from table-offsets field.
// RQ2 - Table sits at the group-table offset, relative to the memory-mapped base region.
// RQ3 - Group count is reported by a capability field; software may use any subset.
// RQ4 - Group slots at or beyond the group count are reserved, may be absent.
// RQ5 - Software leaves unused groups empty; used groups hold a queue and an engine.
// RQ6 - Descriptors on a group's queue may go to any engine of that group.
// RQ7 - Software places every active work queue in exactly one group.
// RQ8 - A work queue is active exactly when its configured size is non-zero.
// RQ9 - Software never places a zero-size work queue in any group.
// RQ10 - An engine in no group stays inactive and receives no descriptors.
// RQ11 - Group sub-registers are writable only while the device is disabled.
// RQ12 - Without configuration support, group sub-registers are always read-only.
// RQ13 - Queue membership is a 256-bit mask; bit n places queue n in the group.
// RQ14 - Queue mask bits beyond the implemented queues are reserved and may be absent.
// RQ15 - Engine membership is a 64-bit mask; bits beyond implemented engines reserved.
// RQ16 - Entries stride 64 bytes; queue mask at 0, engines at 32, flags at 40.
// RQ17 - Writes while locked are discarded without changing stored values.
// RQ18 - Reserved membership and flag bits read as zero and ignore writes.
`ifndef WQG_MAP_VH
`define WQG_MAP_VH

`define WQG_STRIDE_SHIFT 6
`define WQG_QUEUE_MASK_W 256
`define WQG_ENGINE_MASK_W 64
`define WQG_FLAGS_W 32
`define WQG_FLAGS_IMPL_W 28
`define WQG_WORD_SHIFT 3
`define WQG_WORD_QUEUE_LAST 3'h3
`define WQG_WORD_ENGINE 3'h4
`define WQG_WORD_FLAGS 3'h5
`define WQG_LANE_W 64

`endif

// ---- sim/wqg_table_props.sv ----
// Checker for the group table register port and status outputs.
// Assumes it is bound to every wqg_group_table instance.
`timescale 1ns/1ps
`default_nettype none
module wqg_table_props #(
   parameter NUM_GROUPS = 4,
   parameter NUM_WQ = 8,
   parameter NUM_ENG = 4,
   parameter QIDX_W = 3,
   parameter SIZE_W = 16,
   parameter ADDR_W = 32
) (
   // Clock, reset and register port
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic reg_rd_en_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [63:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic [ADDR_W-1:0] table_offset_in,
   // Status and dispatch
   input wire logic [NUM_WQ*SIZE_W-1:0] queue_size_in,
   input wire logic [7:0] group_count_out,
   input wire logic [NUM_WQ-1:0] queue_active_out,
   input wire logic [QIDX_W-1:0] dispatch_queue_in,
   input wire logic [NUM_ENG-1:0] dispatch_engines_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   a_read_answer: assert property (reg_rd_en_in |=> reg_rvalid_out) else $error("read unanswered");
   a_no_stray_data: assert property (!reg_rd_en_in |=> !reg_rvalid_out && reg_rdata_out == 64'h0)
      else $error("stray read data");
   a_flags_top_zero: assert property (reg_rd_en_in && reg_addr_in == table_offset_in + 32'h28
      |=> reg_rdata_out[63:28] == 36'h0) else $error("flags top bits set");
   a_spare_word_zero: assert property (reg_rd_en_in && reg_addr_in == table_offset_in + 32'h30
      |=> reg_rdata_out == 64'h0) else $error("spare word not zero");
   a_unaligned_read_zero: assert property (reg_rd_en_in && reg_addr_in[2:0] != 3'h0
      |=> reg_rdata_out == 64'h0) else $error("unaligned read not zero");
   a_beyond_groups_zero: assert property (reg_rd_en_in && reg_addr_in == table_offset_in + NUM_GROUPS * 64
      |=> reg_rdata_out == 64'h0) else $error("reserved group slot not zero");
   a_group_count: assert property (!$past(reset_in) |-> group_count_out == 8'(NUM_GROUPS))
      else $error("wrong group count");
   a_queue_active: assert property (!$past(reset_in) && !$past(reset_in, 2)
      |-> queue_active_out[0] == ($past(queue_size_in[SIZE_W-1:0]) != 0)) else $error("queue active wrong");
   a_idle_no_dispatch: assert property (!$past(reset_in) && !$past(reset_in, 2)
      && $past(queue_size_in[dispatch_queue_in*SIZE_W +: SIZE_W]) == 0
      && $past(queue_size_in[dispatch_queue_in*SIZE_W +: SIZE_W], 2) == 0
      && $past(dispatch_queue_in) == $past(dispatch_queue_in, 2) |-> dispatch_engines_out == 0)
      else $error("zero-size queue dispatched");
   c_read: cover property (reg_rd_en_in ##1 reg_rvalid_out);
   c_dispatch: cover property (dispatch_engines_out != 0);
   c_idle_queue: cover property (queue_active_out == 0);
endmodule
bind wqg_group_table wqg_table_props #(.NUM_GROUPS(NUM_GROUPS), .NUM_WQ(NUM_WQ), .NUM_ENG(NUM_ENG),
   .QIDX_W(QIDX_W), .SIZE_W(SIZE_W), .ADDR_W(ADDR_W)) chk (.clk_sys_in, .reset_in, .reg_rd_en_in,
   .reg_addr_in, .reg_rdata_out, .reg_rvalid_out, .table_offset_in, .queue_size_in, .group_count_out,
   .queue_active_out, .dispatch_queue_in, .dispatch_engines_out);
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the group configuration table.
// Assumes the default parameters: 4 groups, 8 queues, 4 engines.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam [31:0] BASE = 32'h00000400;
   logic clk_sys_in = 1'b0, reset_in = 1'b1, wr_en = 1'b0, rd_en = 1'b0, dis = 1'b1, sup = 1'b1;
   logic [31:0] addr = 32'h0;
   logic [63:0] wdata = 64'h0;
   logic [127:0] qsize = 128'h0;
   logic [2:0] dq = 3'h0;
   logic [31:0] toff = BASE;
   wire [63:0] rdata;
   wire rvalid;
   wire [7:0] gcount, qact;
   wire [3:0] eact, deng;
   int failures = 0, cmp_count = 0, cyc = 0;
   wqg_group_table uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_wr_en_in(wr_en),
      .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .table_offset_in(toff), .device_disabled_in(dis), .config_support_in(sup),
      .queue_size_in(qsize), .group_count_out(gcount), .queue_active_out(qact),
      .engine_active_out(eact), .dispatch_queue_in(dq), .dispatch_engines_out(deng));
   initial begin
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   task automatic test_done;
      if (failures == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [63:0] d);
      @(posedge clk_sys_in);
      wr_en <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk_sys_in);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [63:0] exp);
      @(posedge clk_sys_in);
      rd_en <= 1'b1; addr <= a;
      @(posedge clk_sys_in);
      rd_en <= 1'b0;
      #1 chk(64'(rvalid), 64'h1);
      chk(rdata, exp);
   endtask
   task automatic t_masks;
      rd(BASE + 32, 64'h0);
      chk(64'(gcount), 64'h4);
      wr(BASE, '1); rd(BASE, 64'hFF);
      wr(BASE + 8, '1); rd(BASE + 8, 64'h0);
      wr(BASE + 32, '1); rd(BASE + 32, 64'hF);
      wr(BASE + 40, '1); rd(BASE + 40, 64'h0FFFFFFF);
      rd(BASE + 48, 64'h0);
      rd(BASE + 1, 64'h0);
      wr(BASE + 256, '1); rd(BASE + 256, 64'h0);
   endtask
   task automatic t_dispatch;
      // Queues 0 and 1 active, each in one group; other groups left empty
      @(posedge clk_sys_in) qsize <= {96'h0, 16'h10, 16'h10};
      wr(BASE, 64'h1); wr(BASE + 32, 64'h5); wr(BASE + 64, 64'h2); wr(BASE + 96, 64'h2);
      dq <= 3'h0;
      repeat (3) @(posedge clk_sys_in);
      #1 chk(64'(deng), 64'h5);
      chk(64'(eact), 64'h7);
      chk(64'(qact), 64'h3);
      @(posedge clk_sys_in) dq <= 3'h1;
      repeat (2) @(posedge clk_sys_in);
      #1 chk(64'(deng), 64'h2);
      @(posedge clk_sys_in) qsize <= {112'h0, 16'h10};
      repeat (3) @(posedge clk_sys_in);
      #1 chk(64'(deng), 64'h0);
   endtask
   task automatic t_lock;
      @(posedge clk_sys_in) dis <= 1'b0;
      wr(BASE + 32, 64'h0); rd(BASE + 32, 64'h5);
      @(posedge clk_sys_in) begin
         dis <= 1'b1; sup <= 1'b0;
      end
      wr(BASE + 32, 64'h0); rd(BASE + 32, 64'h5);
      @(posedge clk_sys_in) sup <= 1'b1;
      wr(BASE + 32, 64'h0); rd(BASE + 32, 64'h0);
   endtask
   task automatic t_offset;
      @(posedge clk_sys_in) toff <= 32'h00000800;
      rd(32'h00000860, 64'h2);
      rd(BASE + 96, 64'h0);
   endtask
   // Cut a hang short well past the expected run of about seventy cycles
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      t_masks();
      t_dispatch();
      t_lock();
      t_offset();
      test_done();
   end
endmodule
`default_nettype wire
